// *** sns_line_driver.sv ***
// Output stage of the digital lines: value plus drive mode to level and enable.
// Assumes the pin pad resolves the wire from line_out and line_oe.
`timescale 1ns/100ps
module sns_line_driver #(
  parameter int LINES = sns_pkg::NUM_LINES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [LINES-1:0] line_value,
  input wire logic [LINES*sns_pkg::MODE_W-1:0] line_output_drive_select,
  output logic [LINES-1:0] line_out,
  output logic [LINES-1:0] line_oe
);
  import sns_pkg::*;

  // Mode and value to {enable, level}; level reads zero while undriven
  function automatic logic [1:0] drive_of(input logic [MODE_W-1:0] mode, input logic value);
    logic [1:0] r;
    r = 2'h0;
    unique case (mode)
      DRV_TRISTATE: r = 2'h0; // Never driven
      DRV_LOW_ONLY: r = {~value, 1'b0}; // Low when off, float when on
      DRV_HIGH_ONLY: r = {value, value}; // High when on, float when off
      DRV_PUSH_PULL: r = {1'b1, value}; // Both levels driven
    endcase
    return r;
  endfunction

  genvar i;
  generate
    for (i = 0; i < LINES; i++) begin : g_line
      wire [MODE_W-1:0] mode = line_output_drive_select[i*MODE_W +: MODE_W]; // This line's mode
      wire [1:0] next_drive = drive_of(mode, line_value[i]); // Decoded pad controls

      // Registered pad controls, each line on its own
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          line_oe[i] <= 1'b0;
          line_out[i] <= 1'b0;
        end else begin
          line_oe[i] <= next_drive[1];
          line_out[i] <= next_drive[0];
        end
      end

      property p_tristate;
        @(posedge aclk) disable iff (!aresetn) (mode == DRV_TRISTATE) |=> !line_oe[i];
      endproperty
      a_tristate: assert property (p_tristate) else $error("Tristate line driven");
      property p_low_only;
        @(posedge aclk) disable iff (!aresetn)
          (mode == DRV_LOW_ONLY) |=> (line_oe[i] == !$past(line_value[i])) && !line_out[i];
      endproperty
      a_low_only: assert property (p_low_only) else $error("Low-only line wrong");
      property p_high_only;
        @(posedge aclk) disable iff (!aresetn)
          (mode == DRV_HIGH_ONLY) |=> (line_oe[i] == $past(line_value[i])) && (line_out[i] == line_oe[i]);
      endproperty
      a_high_only: assert property (p_high_only) else $error("High-only line wrong");
      property p_push_pull;
        @(posedge aclk) disable iff (!aresetn)
          (mode == DRV_PUSH_PULL) |=> line_oe[i] && (line_out[i] == $past(line_value[i]));
      endproperty
      a_push_pull: assert property (p_push_pull) else $error("Push-pull line wrong");
    end
  endgenerate
endmodule

// *** sns_ms_divider.sv ***
// Millisecond enable divider for the sequencer.
// Assumes one clock; clear restarts the phase so ticks align to an acquisition start.
`timescale 1ns/100ps
module sns_ms_divider #(
  parameter int CYCLES = sns_pkg::MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  output logic tick
);
  import sns_pkg::*;
  localparam int CW = $clog2(CYCLES); // Counter width
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1); // Terminal count
  // Clear edge counts as the first cycle, so the next tick is seen CYCLES cycles later
  localparam logic [CW-1:0] RESTART = CW'(1);

  // Refuse a divider too short to give a single-cycle pulse
  generate
    if (CYCLES < 2) begin : g_bad
      $error("Divider needs at least two cycles");
    end
  endgenerate

  logic [CW-1:0] count; // Cycles since last tick
  wire at_last = (count == LAST); // Period complete

  // Count up; clear restarts the phase one count in, else start-to-start drifts a cycle per interval
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      tick <= 1'b0;
    end else if (clear) begin
      count <= RESTART;
      tick <= 1'b0;
    end else begin
      count <= at_last ? '0 : count + 1'b1;
      tick <= at_last;
    end
  end

  property p_tick_single;
    @(posedge aclk) disable iff (!aresetn) tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("Tick longer than one cycle");
endmodule

// *** sns_pkg.sv ***
// Shared constants of the sensor node sample sequencer.
// Assumes a single 25 MHz node clock and a 32-bit AXI4-Lite register bus.
package sns_pkg;
  // Bus geometry
  localparam int ADDR_W = 8; // Byte address width
  localparam int DATA_W = 32; // Register word width
  localparam int STRB_W = DATA_W / 8; // Byte lanes
  localparam int IDX_LSB = 2; // Word index starts above byte bits
  localparam int IDX_W = 3; // Word index width
  localparam int REG_COUNT = 6; // Mapped words
  localparam logic [IDX_W-1:0] IDX_CTRL = 3'h0; // Control word, byte 0x00
  localparam logic [IDX_W-1:0] IDX_INTERVAL = 3'h1; // Sample interval, byte 0x04
  localparam logic [IDX_W-1:0] IDX_LINE_CTRL = 3'h2; // Line values and drive modes, byte 0x08
  localparam logic [IDX_W-1:0] IDX_LINE_IN = 3'h3; // Line pin levels, byte 0x0C
  localparam logic [IDX_W-1:0] IDX_RANGE = 3'h4; // Channel range selections, byte 0x10
  localparam logic [IDX_W-1:0] IDX_STATUS = 3'h5; // Node status, byte 0x14
  localparam logic [1:0] RESP_OKAY = 2'h0; // Normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address answer
  // Field layout
  localparam int CTRL_EN_BIT = 0; // Sequencer enable
  localparam int CTRL_END_BIT = 1; // End node (1) or mesh router (0)
  localparam int CTRL_EXC_LSB = 2; // Excitation setting field
  localparam int EXC_W = 3; // Excitation setting width
  localparam int NUM_LINES = 4; // Digital lines 0 to 3
  localparam int MODE_W = 2; // Drive mode width per line
  localparam int LINE_MODE_LSB = 8; // Drive modes start here
  localparam int NUM_CHANNELS = 4; // Analog channels
  localparam int RANGE_W = 2; // Range code width per channel
  localparam int ST_EXT_BIT = 0; // External power present
  localparam int ST_SLEEP_BIT = 1; // Sleeping
  localparam int ST_POWER_BIT = 2; // Excitation on
  localparam int ST_BUSY_BIT = 3; // Acquisition running
  localparam int ST_LQ_LSB = 8; // Link quality field
  localparam int LQ_W = 8; // Link quality width, percent
  // Excitation settings
  localparam logic [EXC_W-1:0] EXC_0MS = 3'h0;
  localparam logic [EXC_W-1:0] EXC_25MS = 3'h1;
  localparam logic [EXC_W-1:0] EXC_100MS = 3'h2;
  localparam logic [EXC_W-1:0] EXC_250MS = 3'h3;
  localparam logic [EXC_W-1:0] EXC_ALWAYS = 3'h4;
  localparam logic [DATA_W-1:0] LEAD_25_MS = 32'h19; // 25 ms
  localparam logic [DATA_W-1:0] LEAD_100_MS = 32'h64; // 100 ms
  localparam logic [DATA_W-1:0] LEAD_250_MS = 32'hFA; // 250 ms
  localparam logic [DATA_W-1:0] LEAD_NONE_MS = 32'h0; // No lead
  localparam logic [DATA_W-1:0] ONE_MS = 32'h1; // One tick of the interval count
  localparam logic [DATA_W-1:0] INTERVAL_RESET_MS = 32'h3E8; // 1000 ms
  // Line drive modes
  localparam logic [MODE_W-1:0] DRV_TRISTATE = 2'h0;
  localparam logic [MODE_W-1:0] DRV_LOW_ONLY = 2'h1;
  localparam logic [MODE_W-1:0] DRV_HIGH_ONLY = 2'h2;
  localparam logic [MODE_W-1:0] DRV_PUSH_PULL = 2'h3;
  // Range codes: 0 is 10 V, 1 is 5 V, 2 is 2 V, 3 is 0.5 V, all bipolar
  localparam logic [RANGE_W-1:0] RANGE_10V = 2'h0;
  // Timing
  localparam int CLK_PERIOD_NS = 40; // 25 MHz
  localparam int NS_PER_MS = 1000000;
  localparam int MS_CYCLES = NS_PER_MS / CLK_PERIOD_NS; // Cycles in one ms
endpackage

// *** sns_sequencer.sv ***
// Sample sequencer of a four-channel sensor node with AXI4-Lite registers.
// Assumes one 25 MHz clock; the converter answers acq_start with a one-cycle acq_done.
`timescale 1ns/100ps
module sns_sequencer #(
  parameter int MS_CYCLES = sns_pkg::MS_CYCLES,
  parameter logic [31:0] INTERVAL_RESET = sns_pkg::INTERVAL_RESET_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sns_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [sns_pkg::DATA_W-1:0] wdata,
  input wire logic [sns_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [sns_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [sns_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ext_power_in,
  input wire logic [sns_pkg::LQ_W-1:0] link_quality,
  input wire logic acq_done,
  input wire logic [sns_pkg::NUM_LINES-1:0] digital_line_n_in,
  output logic [sns_pkg::NUM_LINES-1:0] digital_line_n_out,
  output logic [sns_pkg::NUM_LINES-1:0] digital_line_n_oe,
  output logic acq_start,
  output logic [sns_pkg::NUM_CHANNELS*sns_pkg::RANGE_W-1:0] acq_range,
  output logic sensor_power_en,
  output logic sleep_req
);
  import sns_pkg::*;

  // Refuse a millisecond count the divider cannot serve
  generate
    if (MS_CYCLES < 2) begin : g_bad
      $error("MS_CYCLES must be at least two");
    end
  endgenerate

  // Word index of a byte address
  function automatic logic [IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a);
    return a[IDX_LSB +: IDX_W];
  endfunction
  // Address maps onto a word
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:IDX_LSB+IDX_W] == '0) && (a[IDX_LSB +: IDX_W] < IDX_W'(REG_COUNT));
  endfunction
  // Merge written bytes into an old word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
                                              input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACQ = 3'b100
  } sns_state_type;

  // Software state
  logic ctrl_enable; // Sequencer running
  logic ctrl_end_node; // End node, sleeps
  logic [EXC_W-1:0] exc_mode; // Excitation setting
  logic [DATA_W-1:0] interval_ms; // Sample interval in ms; fractional seconds at ms resolution
  logic [NUM_LINES-1:0] line_value; // Line on/off values
  logic [NUM_LINES*MODE_W-1:0] line_mode; // Drive modes
  logic [NUM_CHANNELS*RANGE_W-1:0] range_sel; // Range codes per channel
  // Pin synchronisers: meta stage read only by the sync stage
  logic [NUM_LINES:0] pin_meta;
  logic [NUM_LINES:0] pin_sync;
  logic [LQ_W-1:0] link_q; // Captured link quality

  // Bus state
  logic aw_held; // Write address waiting
  logic w_held; // Write data waiting
  logic [ADDR_W-1:0] aw_addr; // Held write address
  logic [DATA_W-1:0] w_data; // Held write data
  logic [STRB_W-1:0] w_strb; // Held strobes

  // Sequencer state
  sns_state_type state;
  sns_state_type next_state;
  logic [DATA_W-1:0] ms_left; // Ms until the next acquisition start
  logic [DATA_W-1:0] next_ms_left;
  logic next_acq_start;
  logic perm_on; // Permanent excitation latched
  wire ms_tick; // One-cycle ms enable

  // Register views for read and merge
  logic [DATA_W-1:0] reg_view [REG_COUNT];
  assign reg_view[IDX_CTRL] = DATA_W'({exc_mode, ctrl_end_node, ctrl_enable});
  assign reg_view[IDX_INTERVAL] = interval_ms;
  assign reg_view[IDX_LINE_CTRL] = DATA_W'({line_mode, {(LINE_MODE_LSB-NUM_LINES){1'b0}}, line_value});
  assign reg_view[IDX_LINE_IN] = DATA_W'(pin_sync[NUM_LINES-1:0]); // Pin levels
  assign reg_view[IDX_RANGE] = DATA_W'(range_sel);
  assign reg_view[IDX_STATUS] = DATA_W'({link_q, {(ST_LQ_LSB-ST_BUSY_BIT-1){1'b0}}, (state == ST_ACQ),
                                         sensor_power_en, sleep_req, pin_sync[NUM_LINES]});

  // Write channel handshake decode
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire wr_fire = aw_held && w_held && !bvalid; // Both halves present
  wire next_aw_held = (aw_held || aw_take) && !wr_fire;
  wire next_w_held = (w_held || w_take) && !wr_fire;
  wire next_bvalid = (bvalid && !bready) || wr_fire;
  wire wr_hit = addr_hit(aw_addr);
  wire [IDX_W-1:0] wr_idx = addr_idx(aw_addr);
  wire [DATA_W-1:0] wr_word = merge(reg_view[wr_idx], w_data, w_strb);
  wire wr_ok = wr_fire && wr_hit;
  // Read channel decode
  wire ar_take = arvalid && arready;
  wire next_rvalid = (rvalid && !rready) || ar_take;
  wire rd_hit = addr_hit(araddr);

  // Write handshakes; one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= !next_aw_held && !next_bvalid;
      wready <= !next_w_held && !next_bvalid;
      bvalid <= next_bvalid;
      if (wr_fire) begin
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Capture write payloads as each channel is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (aw_take) begin
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  // Read path; data registered on the address edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (ar_take) begin
        rdata <= rd_hit ? reg_view[addr_idx(araddr)] : '0;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Control and interval words; status words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_enable <= 1'b0;
      ctrl_end_node <= 1'b0;
      exc_mode <= EXC_0MS;
      interval_ms <= INTERVAL_RESET;
    end else if (wr_ok && wr_idx == IDX_CTRL) begin
      ctrl_enable <= wr_word[CTRL_EN_BIT];
      ctrl_end_node <= wr_word[CTRL_END_BIT];
      exc_mode <= wr_word[CTRL_EXC_LSB +: EXC_W];
    end else if (wr_ok && wr_idx == IDX_INTERVAL) begin
      interval_ms <= wr_word;
    end
  end

  // Line and range words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_value <= '0;
      line_mode <= {NUM_LINES{DRV_TRISTATE}};
      range_sel <= {NUM_CHANNELS{RANGE_10V}};
    end else if (wr_ok && wr_idx == IDX_LINE_CTRL) begin
      line_value <= wr_word[NUM_LINES-1:0];
      line_mode <= wr_word[LINE_MODE_LSB +: NUM_LINES*MODE_W];
    end else if (wr_ok && wr_idx == IDX_RANGE) begin
      range_sel <= wr_word[NUM_CHANNELS*RANGE_W-1:0];
    end
  end

  // Two-stage capture of pins; link quality is same-clock logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      link_q <= '0;
    end else begin
      pin_meta <= {ext_power_in, digital_line_n_in};
      pin_sync <= pin_meta;
      link_q <= link_quality;
    end
  end

  // Interval of zero would never pace; hold it to one ms
  wire [DATA_W-1:0] interval_eff = (interval_ms == '0) ? ONE_MS : interval_ms;
  wire [DATA_W-1:0] lead_ms = (exc_mode == EXC_25MS) ? LEAD_25_MS :
                              (exc_mode == EXC_100MS) ? LEAD_100_MS :
                              (exc_mode == EXC_250MS) ? LEAD_250_MS : LEAD_NONE_MS;
  wire is_perm = (exc_mode == EXC_ALWAYS);

  // Restart the ms phase at each start so the lead lands on whole ms
  sns_ms_divider #(
    .CYCLES(MS_CYCLES)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(next_acq_start || state == ST_IDLE),
    .tick(ms_tick)
  );

  // Next state; the interval runs from start to start, also during acquisition
  always_comb begin
    next_state = state;
    next_ms_left = ms_left;
    next_acq_start = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (ctrl_enable) begin
          next_state = ST_WAIT;
          next_ms_left = interval_eff;
        end
      end
      ST_WAIT: begin
        if (!ctrl_enable) begin
          next_state = ST_IDLE;
        end else if (ms_tick && ms_left <= ONE_MS) begin
          next_state = ST_ACQ; // Interval elapsed
          next_acq_start = 1'b1;
          next_ms_left = interval_eff;
        end else if (ms_tick) begin
          next_ms_left = ms_left - ONE_MS;
        end
      end
      ST_ACQ: begin
        // Saturate at one so an overlong acquisition starts the next at the first ms tick back in wait
        if (ms_tick && ms_left > ONE_MS) begin
          next_ms_left = ms_left - ONE_MS;
        end
        if (acq_done) begin
          next_state = ctrl_enable ? ST_WAIT : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Permanent mode latches on at an acquisition start and holds
  wire next_perm = is_perm && (perm_on || next_acq_start);
  // Power: during acquisition, inside the lead window, or permanent
  wire lead_window = (next_state == ST_WAIT) && (lead_ms != LEAD_NONE_MS) && (next_ms_left <= lead_ms);
  wire next_power = next_perm || (next_state == ST_ACQ) || lead_window;
  // Sleep only for end nodes, waiting, with power off
  wire next_sleep = ctrl_end_node && (next_state == ST_WAIT) && !next_power;

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      ms_left <= '0;
      perm_on <= 1'b0;
      acq_start <= 1'b0;
      sensor_power_en <= 1'b0;
      sleep_req <= 1'b0;
    end else begin
      state <= next_state;
      ms_left <= next_ms_left;
      perm_on <= next_perm;
      acq_start <= next_acq_start;
      sensor_power_en <= next_power;
      sleep_req <= next_sleep;
    end
  end

  // Range codes frozen for the acquisition that uses them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acq_range <= {NUM_CHANNELS{RANGE_10V}};
    end else if (next_acq_start) begin
      acq_range <= range_sel;
    end
  end

  sns_line_driver #(
    .LINES(NUM_LINES)
  ) u_lines (
    .aclk(aclk),
    .aresetn(aresetn),
    .line_value(line_value),
    .line_output_drive_select(line_mode),
    .line_out(digital_line_n_out),
    .line_oe(digital_line_n_oe)
  );

  // Start pulse is single and lands in the acquisition state
  sequence s_start;
    acq_start && state == ST_ACQ;
  endsequence
  property p_start_pulse;
    @(posedge aclk) disable iff (!aresetn) s_start |=> !acq_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("Start pulse not single");
  property p_power_at_start;
    @(posedge aclk) disable iff (!aresetn) acq_start |-> sensor_power_en;
  endproperty
  a_power_at_start: assert property (p_power_at_start) else $error("No power at acquisition start");
  property p_zero_lead_off;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_WAIT && exc_mode == EXC_0MS && $stable(exc_mode) && !perm_on) |-> !sensor_power_en;
  endproperty
  a_zero_lead_off: assert property (p_zero_lead_off) else $error("Power on before zero-lead start");
  property p_lead_window;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_WAIT && $stable(exc_mode) && lead_ms != LEAD_NONE_MS && ms_left <= lead_ms) |-> sensor_power_en;
  endproperty
  a_lead_window: assert property (p_lead_window) else $error("Power off inside lead window");
  property p_perm_hold;
    @(posedge aclk) disable iff (!aresetn) (perm_on && is_perm) |=> sensor_power_en;
  endproperty
  a_perm_hold: assert property (p_perm_hold) else $error("Permanent power dropped");
  sequence s_done_zero;
    state == ST_ACQ && acq_done && exc_mode == EXC_0MS && !perm_on;
  endsequence
  property p_off_after_done;
    @(posedge aclk) disable iff (!aresetn) s_done_zero |=> !sensor_power_en && state != ST_ACQ;
  endproperty
  a_off_after_done: assert property (p_off_after_done) else $error("Power stayed on after acquisition");
  property p_sleep_dark;
    @(posedge aclk) disable iff (!aresetn) sleep_req |-> !sensor_power_en && state == ST_WAIT;
  endproperty
  a_sleep_dark: assert property (p_sleep_dark) else $error("Sleep with power or outside wait");
  property p_router_awake;
    @(posedge aclk) disable iff (!aresetn) !ctrl_end_node |=> !sleep_req;
  endproperty
  a_router_awake: assert property (p_router_awake) else $error("Router node asleep");
  property p_range_applied;
    @(posedge aclk) disable iff (!aresetn) next_acq_start |=> acq_range == $past(range_sel);
  endproperty
  a_range_applied: assert property (p_range_applied) else $error("Range not applied at start");
endmodule

// *** sns_sequencer_tb.sv ***
// Self-checking bench of the sensor node sample sequencer.
// Assumes sns_pkg and the design files are compiled before it.
`timescale 1ns/100ps
module sns_sequencer_tb;
  import sns_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic ext_power_in, acq_done, acq_start, sensor_power_en, sleep_req;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [LQ_W-1:0] link_quality;
  logic [NUM_LINES-1:0] digital_line_n_in, digital_line_n_out, digital_line_n_oe;
  logic [NUM_CHANNELS*RANGE_W-1:0] acq_range;
  int num_errors = 0;
  int comparisons = 0;
  // Short millisecond so a 300 ms interval takes 1200 cycles
  localparam int TB_MS = 4;
  sns_sequencer #(.MS_CYCLES(TB_MS)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ext_power_in(ext_power_in), .link_quality(link_quality), .acq_done(acq_done),
    .digital_line_n_in(digital_line_n_in), .digital_line_n_out(digital_line_n_out),
    .digital_line_n_oe(digital_line_n_oe), .acq_start(acq_start), .acq_range(acq_range),
    .sensor_power_en(sensor_power_en), .sleep_req(sleep_req)
  );
  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic tally_and_finish;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One edge with a bound, so no wait hangs
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 4000) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  // Write: AW and W released each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      step(n);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      step(n);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask
  task automatic t_regs;
    rd_reg(8'h04); chk(rd, 32'h3E8);
    rd_reg(8'h20); chk(32'(rs), 32'(RESP_SLVERR));
    wr(8'h40, 32'h0); chk(32'(rs), 32'(RESP_SLVERR));
    ext_power_in <= 1'b1; link_quality <= 8'h5A;
    repeat (4) @(posedge aclk);
    rd_reg(8'h14); chk(rd & 32'hFF01, 32'h5A01);
    wr(8'h10, 32'h1B);
    $display("t_regs done");
  endtask
  // Every drive mode with both line values on every line
  task automatic t_lines;
    logic [3:0] v, oe;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        v = k ? 4'hA : 4'h5;
        oe = m == 0 ? 4'h0 : m == 1 ? ~v : m == 2 ? v : 4'hF;
        wr(8'h08, {16'h0, {4{2'(m)}}, 4'h0, v});
        repeat (2) @(posedge aclk);
        chk(32'(digital_line_n_oe), 32'(oe));
        chk(32'(digital_line_n_out), 32'(v & oe));
      end
    end
    rd_reg(8'h08); chk(rd, 32'hFF0A);
    digital_line_n_in <= 4'h9;
    repeat (3) @(posedge aclk);
    rd_reg(8'h0C); chk(rd, 32'h9);
    $display("t_lines done");
  endtask
  // End node or router, 300 ms interval, one excitation setting
  task automatic t_seq(input logic [2:0] ex, input int lead, input logic end_n);
    int n = 0;
    int p = -1;
    wr(8'h04, 32'h12C);
    wr(8'h00, {27'h0, ex, end_n, 1'b1});
    do begin
      step(n);
      if (n == 8) chk(32'(sleep_req), 32'(end_n));
      if (p < 0 && sensor_power_en === 1'b1) p = n;
    end while (acq_start !== 1'b1);
    chk(n - p, lead * TB_MS);
    chk(32'(acq_range), 32'h1B);
    n = 0;
    acq_done <= 1'b1;
    step(n);
    acq_done <= 1'b0;
    repeat (3) step(n);
    chk(32'(sensor_power_en), 32'(ex == EXC_ALWAYS));
    chk(32'(sleep_req), 32'(end_n && ex != EXC_ALWAYS));
    do step(n); while (acq_start !== 1'b1);
    chk(n, 300 * TB_MS);
    acq_done <= 1'b1;
    step(n);
    acq_done <= 1'b0;
    wr(8'h00, 32'h0);
    $display("t_seq done for setting %0d", ex);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, acq_done, ext_power_in} = 8'h0;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'h0;
    link_quality = 8'h0; digital_line_n_in = 4'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_lines();
    t_seq(EXC_0MS, 0, 1'b1);
    t_seq(EXC_25MS, 25, 1'b1);
    t_seq(EXC_100MS, 100, 1'b1);
    t_seq(EXC_250MS, 250, 1'b1);
    t_seq(EXC_0MS, 0, 1'b0);
    t_seq(EXC_ALWAYS, 0, 1'b1);
    tally_and_finish();
  end
endmodule
